/* File: design/aolu_defs.vh */
// constants shared by the accumulator logic unit and its stack
`ifndef AOLU_DEFS_VH
`define AOLU_DEFS_VH

// data widths
`define AOLU_ACC_W              32
`define AOLU_HALF_W             16
`define AOLU_OPC_W              4
`define AOLU_CNT_W              6
`define AOLU_LVL_W              4

// accumulator stack depth, a plain default
`define AOLU_STACK_DEPTH        8

// legal bit-run length
`define AOLU_RUN_MIN            6'h01
`define AOLU_RUN_MAX            6'h20

// operation codes
`define AOLU_NOP_OP             4'h0
`define AOLU_LOAD_OP            4'h1
`define AOLU_PUSH_OP            4'h2
`define AOLU_OR_WORD_OP         4'h3
`define AOLU_OR_DOUBLE_WORD_OP  4'h4
`define AOLU_OR_BIT_RUN_OP      4'h5
`define AOLU_OR_STACK_OP        4'h6
`define AOLU_XOR_WORD_OP        4'h7
`define AOLU_XOR_DOUBLE_WORD_OP 4'h8
`define AOLU_XOR_BIT_RUN_OP     4'h9
`define AOLU_XOR_STACK_OP       4'hA

// reset values
`define AOLU_ACC_RST            32'h00000000
`define AOLU_LVL_RST            4'h0

`endif

/* File: design/aolu_stack.v */
// accumulator stack: top entry and depth come straight from registers
`timescale 1ns/1ps
`include "aolu_defs.vh"

module aolu_stack (
   // clock and reset
   input  wire                     clk,
   input  wire                     rst_n,
   // control
   input  wire                     push,
   input  wire                     pop,
   input  wire [`AOLU_ACC_W-1:0]   push_data,
   // state
   output wire [`AOLU_ACC_W-1:0]   top_data,
   output wire [`AOLU_LVL_W-1:0]   level
);

   reg  [`AOLU_ACC_W-1:0] entry_reg [0:`AOLU_STACK_DEPTH-1];
   reg  [`AOLU_LVL_W-1:0] level_reg;
   integer                i;

   assign top_data = entry_reg[0];
   assign level    = level_reg;

   // a push onto a full stack drops the bottom entry, as a shift stack must
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < `AOLU_STACK_DEPTH; i = i + 1) begin
            entry_reg[i] <= `AOLU_ACC_RST;
         end
         level_reg <= `AOLU_LVL_RST;
      end else if (push) begin
         entry_reg[0] <= push_data;
         for (i = 1; i < `AOLU_STACK_DEPTH; i = i + 1) begin
            entry_reg[i] <= entry_reg[i-1];
         end
         if (level_reg != `AOLU_STACK_DEPTH) begin
            level_reg <= level_reg + 4'h1;
         end
      end else if (pop) begin
         for (i = 0; i < `AOLU_STACK_DEPTH - 1; i = i + 1) begin
            entry_reg[i] <= entry_reg[i+1];
         end
         entry_reg[`AOLU_STACK_DEPTH-1] <= `AOLU_ACC_RST;
         if (level_reg != `AOLU_LVL_RST) begin
            level_reg <= level_reg - 4'h1;
         end
      end
   end

endmodule

/* File: design/aolu_unit.v */
// accumulator inclusive-or / exclusive-or logic unit with result flags
//
// Behaviour
// - double-word or: full 32-bit accumulator ORed with 32-bit operand, result kept
// - bit-run or: accumulator ORed with a run of 1 to 32 bits
// - stack or: accumulator ORed with top stack entry, result kept
// - stack operations pop the top entry, remaining entries move up one level
// - single-word xor: low 16 accumulator bits XORed, only zero flag reported
// - double-word xor: full accumulator XORed with 32-bit operand, result kept
// - bit-run xor: accumulator XORed with a run of 1 to 32 bits
// - zero flag set when the result is zero, cleared otherwise
// - double, bit-run and stack operations update the negative flag
// - negative means the most significant result bit is one
// - a flag changes only on operations that drive it
`timescale 1ns/1ps
`include "aolu_defs.vh"

module aolu_unit (
   // clock and reset
   input  wire                     MCLK,
   input  wire                     NRST,
   // request from the sequencer
   input  wire                     OP_VALID,
   input  wire [`AOLU_OPC_W-1:0]   OP_CODE,
   input  wire [`AOLU_ACC_W-1:0]   OPERAND,
   input  wire [`AOLU_CNT_W-1:0]   BIT_COUNT,
   // accumulator and stack state
   output wire [`AOLU_ACC_W-1:0]   ACC,
   output wire [`AOLU_LVL_W-1:0]   STACK_LEVEL,
   // result flags
   output wire                     ZERO_RESULT_FLAG,
   output wire                     NEGATIVE_RESULT_FLAG,
   // completion
   output wire                     OP_DONE,
   output wire                     OP_ERROR
);

   // kinds of operand, one-hot
   localparam [3:0] KIND_WORD   = 4'h1;
   localparam [3:0] KIND_DOUBLE = 4'h2;
   localparam [3:0] KIND_RUN    = 4'h4;
   localparam [3:0] KIND_STACK  = 4'h8;

   reg  [`AOLU_ACC_W-1:0]  acc_reg;
   reg  [`AOLU_ACC_W-1:0]  acc_next;
   reg                     zero_reg;
   reg                     zero_next;
   reg                     neg_reg;
   reg                     neg_next;
   reg                     done_reg;
   reg                     done_next;
   reg                     err_reg;
   reg                     err_next;

   reg  [3:0]              kind;
   reg                     is_xor;
   reg                     is_logic;
   reg                     is_load;
   reg                     is_push;
   reg  [`AOLU_ACC_W-1:0]  run_mask;
   reg  [`AOLU_ACC_W-1:0]  operand_eff;
   reg  [`AOLU_ACC_W-1:0]  logic_res;
   reg                     bad_op;
   reg                     stack_pop;
   reg                     stack_push;
   integer                 i;

   wire [`AOLU_ACC_W-1:0]  stack_top;
   wire [`AOLU_LVL_W-1:0]  stack_level;
   wire                    stack_empty;
   wire                    run_ok;

   assign stack_empty = (stack_level == `AOLU_LVL_RST);
   assign run_ok      = (BIT_COUNT >= `AOLU_RUN_MIN) && (BIT_COUNT <= `AOLU_RUN_MAX);

   // opcode decode
   always @* begin
      kind     = 4'h0;
      is_xor   = 1'b0;
      is_logic = 1'b1;
      is_load  = 1'b0;
      is_push  = 1'b0;
      case (OP_CODE)
         `AOLU_OR_WORD_OP: begin
            kind = KIND_WORD;
         end
         `AOLU_OR_DOUBLE_WORD_OP: begin
            kind = KIND_DOUBLE;
         end
         `AOLU_OR_BIT_RUN_OP: begin
            kind = KIND_RUN;
         end
         `AOLU_OR_STACK_OP: begin
            kind = KIND_STACK;
         end
         `AOLU_XOR_WORD_OP: begin
            kind   = KIND_WORD;
            is_xor = 1'b1;
         end
         `AOLU_XOR_DOUBLE_WORD_OP: begin
            kind   = KIND_DOUBLE;
            is_xor = 1'b1;
         end
         `AOLU_XOR_BIT_RUN_OP: begin
            kind   = KIND_RUN;
            is_xor = 1'b1;
         end
         `AOLU_XOR_STACK_OP: begin
            kind   = KIND_STACK;
            is_xor = 1'b1;
         end
         `AOLU_LOAD_OP: begin
            is_logic = 1'b0;
            is_load  = 1'b1;
         end
         `AOLU_PUSH_OP: begin
            is_logic = 1'b0;
            is_push  = 1'b1;
         end
         default: begin
            is_logic = 1'b0;
         end
      endcase
   end

   // bit-run mask; the sequencer already zero-extends, the mask guards a sloppy run
   always @* begin
      run_mask = `AOLU_ACC_RST;
      for (i = 0; i < `AOLU_ACC_W; i = i + 1) begin
         run_mask[i] = (i[`AOLU_CNT_W-1:0] < BIT_COUNT);
      end
   end

   // operand select and the logic itself
   always @* begin
      case (kind)
         KIND_WORD: begin
            operand_eff = {{`AOLU_HALF_W{1'b0}}, OPERAND[`AOLU_HALF_W-1:0]};
         end
         KIND_DOUBLE: begin
            operand_eff = OPERAND;
         end
         KIND_RUN: begin
            operand_eff = OPERAND & run_mask;
         end
         KIND_STACK: begin
            operand_eff = stack_top;
         end
         default: begin
            operand_eff = OPERAND;
         end
      endcase
      if (is_xor) begin
         logic_res = acc_reg ^ operand_eff;
      end else begin
         logic_res = acc_reg | operand_eff;
      end
   end

   // next state; a refused request changes nothing and only pulses the error
   always @* begin
      acc_next   = acc_reg;
      zero_next  = zero_reg;
      neg_next   = neg_reg;
      done_next  = 1'b0;
      err_next   = 1'b0;
      stack_pop  = 1'b0;
      stack_push = 1'b0;
      bad_op     = 1'b0;
      if (OP_VALID) begin
         if (is_logic && (kind == KIND_RUN) && !run_ok) begin
            bad_op = 1'b1;
         end
         if (is_logic && (kind == KIND_STACK) && stack_empty) begin
            bad_op = 1'b1;
         end
         if (!is_logic && !is_load && !is_push && (OP_CODE != `AOLU_NOP_OP)) begin
            bad_op = 1'b1;
         end
         if (bad_op) begin
            err_next = 1'b1;
         end else if (is_load) begin
            acc_next  = OPERAND;
            done_next = 1'b1;
         end else if (is_push) begin
            stack_push = 1'b1;
            done_next  = 1'b1;
         end else if (is_logic && (kind == KIND_WORD)) begin
            // upper half kept; negative flag untouched by 16-bit forms
            acc_next  = {acc_reg[`AOLU_ACC_W-1:`AOLU_HALF_W],
                         logic_res[`AOLU_HALF_W-1:0]};
            zero_next = (logic_res[`AOLU_HALF_W-1:0] == 16'h0000);
            done_next = 1'b1;
         end else if (is_logic) begin
            acc_next  = logic_res;
            zero_next = (logic_res == 32'h00000000);
            neg_next  = logic_res[`AOLU_ACC_W-1];
            stack_pop = (kind == KIND_STACK);
            done_next = 1'b1;
         end else begin
            done_next = 1'b1;
         end
      end
   end

   // registers; load and push leave both flags alone
   always @(posedge MCLK or negedge NRST) begin
      if (!NRST) begin
         acc_reg  <= `AOLU_ACC_RST;
         zero_reg <= 1'b0;
         neg_reg  <= 1'b0;
         done_reg <= 1'b0;
         err_reg  <= 1'b0;
      end else begin
         acc_reg  <= acc_next;
         zero_reg <= zero_next;
         neg_reg  <= neg_next;
         done_reg <= done_next;
         err_reg  <= err_next;
      end
   end

   aolu_stack u_stack (
      .clk       (MCLK),
      .rst_n     (NRST),
      .push      (stack_push),
      .pop       (stack_pop),
      .push_data (acc_reg),
      .top_data  (stack_top),
      .level     (stack_level)
   );

   assign ACC                  = acc_reg;
   assign STACK_LEVEL          = stack_level;
   assign ZERO_RESULT_FLAG     = zero_reg;
   assign NEGATIVE_RESULT_FLAG = neg_reg;
   assign OP_DONE              = done_reg;
   assign OP_ERROR             = err_reg;

endmodule

/* File: sim/aolu_chk.sv */
// concurrent checks on the logic unit ports
`timescale 1ns/1ps
module aolu_chk (
   // clock and reset
   input wire        MCLK,
   input wire        NRST,
   // request
   input wire        OP_VALID,
   input wire [3:0]  OP_CODE,
   input wire [31:0] OPERAND,
   input wire [5:0]  BIT_COUNT,
   // state and flags
   input wire [31:0] ACC,
   input wire [3:0]  STACK_LEVEL,
   input wire        ZERO_RESULT_FLAG,
   input wire        NEGATIVE_RESULT_FLAG,
   input wire        OP_DONE,
   input wire        OP_ERROR
);
   wire        v   = OP_VALID;
   wire        ok  = (BIT_COUNT != 6'h00) && (BIT_COUNT <= 6'h20);
   wire [31:0] msk = (BIT_COUNT >= 6'h20) ? 32'hFFFFFFFF : (32'h1 << BIT_COUNT) - 32'h1;
   wire        full = v && (OP_CODE inside {4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA});
   default clocking @(posedge MCLK); endclocking
   default disable iff (!NRST);
   or_dbl_a: assert property (v && OP_CODE == 4'h4 |=> ACC == ($past(ACC) | $past(OPERAND)))
      else $error("or double result wrong");
   or_run_a: assert property (v && OP_CODE == 4'h5 && ok |=>
      ACC == ($past(ACC) | ($past(OPERAND) & $past(msk))))
      else $error("or run result wrong");
   xor_word_a: assert property (v && OP_CODE == 4'h7 |=>
      ACC == ($past(ACC) ^ ($past(OPERAND) & 32'h0000FFFF)))
      else $error("xor word result wrong");
   xor_dbl_a: assert property (v && OP_CODE == 4'h8 |=> ACC == ($past(ACC) ^ $past(OPERAND)))
      else $error("xor double result wrong");
   xor_run_a: assert property (v && OP_CODE == 4'h9 && ok |=>
      ACC == ($past(ACC) ^ ($past(OPERAND) & $past(msk))))
      else $error("xor run result wrong");
   zero_flag_a: assert property (full ##1 OP_DONE |-> ZERO_RESULT_FLAG == (ACC == 32'h0))
      else $error("zero flag wrong");
   neg_flag_a: assert property (full ##1 OP_DONE |-> NEGATIVE_RESULT_FLAG == ACC[31])
      else $error("negative flag wrong");
   flag_keep_a: assert property (v && OP_CODE <= 4'h2 |=>
      $stable(ZERO_RESULT_FLAG) && $stable(NEGATIVE_RESULT_FLAG))
      else $error("flag changed by untouched op");
   pop_level_a: assert property (v && OP_CODE inside {4'h6, 4'hA} && STACK_LEVEL != 4'h0 |=>
      STACK_LEVEL == $past(STACK_LEVEL) - 4'h1)
      else $error("stack level not popped");
   cover property (v && OP_CODE == 4'hA ##1 OP_DONE);
   cover property (v && OP_CODE == 4'h9 && BIT_COUNT == 6'h20);
   cover property (OP_ERROR);
endmodule
bind aolu_unit aolu_chk aolu_chk_i (.MCLK(MCLK), .NRST(NRST), .OP_VALID(OP_VALID),
   .OP_CODE(OP_CODE), .OPERAND(OPERAND), .BIT_COUNT(BIT_COUNT), .ACC(ACC),
   .STACK_LEVEL(STACK_LEVEL), .ZERO_RESULT_FLAG(ZERO_RESULT_FLAG),
   .NEGATIVE_RESULT_FLAG(NEGATIVE_RESULT_FLAG), .OP_DONE(OP_DONE), .OP_ERROR(OP_ERROR));

/* File: sim/aolu_seq_model.sv */
// sequencer and operand memory model presenting one request per go
`timescale 1ns/1ps
module aolu_seq_model (
   input  wire        clk,
   input  wire        go,
   input  wire [3:0]  opc,
   input  wire [15:0] w_lo,
   input  wire [15:0] w_hi,
   input  wire [5:0]  cnt,
   output reg         op_valid = 1'b0,
   output reg  [3:0]  op_code = 4'h0,
   output reg  [31:0] operand = 32'h0,
   output reg  [5:0]  bit_count = 6'h00
);
   wire [31:0] j = {w_hi, w_lo};
   wire [31:0] m = (cnt >= 6'h20) ? 32'hFFFFFFFF : (32'h1 << cnt) - 32'h1;
   wire        run = (opc == 4'h5) || (opc == 4'h9);
   // idle operand toggles so a stale value is never mistaken for a request
   always @(posedge clk) begin
      op_valid <= go;
      op_code <= go ? opc : ~op_code;
      operand <= go ? (run ? (j & m) : j) : ~operand;
      bit_count <= go ? cnt : ~bit_count;
   end
endmodule

/* File: sim/aolu_unit_tb_top.sv */
// self-checking bench for the accumulator logic unit
`timescale 1ns/1ps
module aolu_unit_tb_top;
   reg         mclk = 1'b0;
   reg         nrst = 1'b0;
   reg         go = 1'b0;
   reg  [3:0]  opc = 4'h0;
   reg  [15:0] w_lo = 16'h0;
   reg  [15:0] w_hi = 16'h0;
   reg  [5:0]  cnt = 6'h0;
   wire        vld, zf, nf, done, err;
   wire [3:0]  code, lvl;
   wire [31:0] opnd, acc;
   wire [5:0]  bc;
   integer     fail_count = 0;
   integer     checks_done = 0;
   integer     cyc = 0;
   integer     i;
   reg  [31:0] rnd = 32'h43;
   reg  [31:0] x, y, m_acc;
   reg  [31:0] m_stk [0:7];
   reg  [3:0]  m_lvl;
   reg         m_zf, m_nf, m_err;

   aolu_seq_model aolu_seq_model_i (.clk(mclk), .go(go), .opc(opc), .w_lo(w_lo), .w_hi(w_hi),
      .cnt(cnt), .op_valid(vld), .op_code(code), .operand(opnd), .bit_count(bc));
   aolu_unit aolu_unit_i (.MCLK(mclk), .NRST(nrst), .OP_VALID(vld), .OP_CODE(code),
      .OPERAND(opnd), .BIT_COUNT(bc), .ACC(acc), .STACK_LEVEL(lvl), .ZERO_RESULT_FLAG(zf),
      .NEGATIVE_RESULT_FLAG(nf), .OP_DONE(done), .OP_ERROR(err));

   initial forever #12.5 mclk = ~mclk;

   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function [31:0] rmask(input [5:0] c);
      rmask = (c >= 6'h20) ? 32'hFFFFFFFF : (32'h1 << c) - 32'h1;
   endfunction

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         checks_done = checks_done + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
         end
      end
   endtask

   task end_sim;
      begin
         $display("checks %0d mismatches %0d", checks_done, fail_count);
         if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   // one request through the sequencer, then compare against the bench model
   task op(input [3:0] c, input [31:0] d, input [5:0] n);
      integer k;
      begin
         @(posedge mclk);
         go <= 1'b1;
         opc <= c;
         w_lo <= d[15:0];
         w_hi <= d[31:16];
         cnt <= n;
         @(posedge mclk);
         go <= 1'b0;
         k = 0;
         @(negedge mclk);
         while (done !== 1'b1 && err !== 1'b1 && k < 4) begin
            @(negedge mclk);
            k = k + 1;
         end
         m_err = 1'b0;
         case (c)
            4'h0: ;
            4'h1: m_acc = d;
            4'h2: begin
               for (k = 7; k > 0; k--) m_stk[k] = m_stk[k-1];
               m_stk[0] = m_acc;
               if (m_lvl < 4'h8) m_lvl++;
            end
            4'h3, 4'h7: y = d & 32'h0000FFFF;
            4'h4, 4'h8: y = d;
            4'h5, 4'h9: begin
               y = d & rmask(n);
               m_err = (n == 6'h0) || (n > 6'h20);
            end
            4'h6, 4'hA: begin
               y = m_stk[0];
               m_err = (m_lvl == 4'h0);
               if (!m_err) begin
                  for (k = 0; k < 7; k++) m_stk[k] = m_stk[k+1];
                  m_stk[7] = 32'h0;
                  m_lvl--;
               end
            end
            default: m_err = 1'b1;
         endcase
         if (!m_err && c >= 4'h3) begin
            m_acc = (c <= 4'h6) ? (m_acc | y) : (m_acc ^ y);
            if (c == 4'h3 || c == 4'h7)
               m_zf = (m_acc[15:0] == 16'h0);
            else begin
               m_zf = (m_acc == 32'h0);
               m_nf = m_acc[31];
            end
         end
         chk("acc", m_acc, acc);
         chk("level", {28'h0, m_lvl}, {28'h0, lvl});
         chk("zero", {31'h0, m_zf}, {31'h0, zf});
         chk("neg", {31'h0, m_nf}, {31'h0, nf});
         chk("refused", {31'h0, m_err}, {31'h0, err});
         chk("done", {31'h0, ~m_err}, {31'h0, done});
      end
   endtask

   // bounded run: three cycles per request
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         fail_count = fail_count + 1;
         end_sim;
      end
   end

   initial begin
      for (i = 0; i < 8; i++) m_stk[i] = 32'h0;
      m_acc = 32'h0;
      m_lvl = 4'h0;
      m_zf = 1'b0;
      m_nf = 1'b0;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      op(4'h6, 32'h0, 6'h0);
      op(4'h1, 32'h80000000, 6'h0);
      op(4'h4, 32'h00000001, 6'h0);
      op(4'h8, 32'h80000001, 6'h0);
      op(4'h1, 32'hFFFF1234, 6'h0);
      op(4'h7, 32'hABCD1234, 6'h0);
      for (i = 0; i < 9; i++) begin
         op(4'h1, 32'h11111111 * i, 6'h0);
         op(4'h2, 32'h0, 6'h0);
      end
      op(4'h5, 32'hFFFFFFFF, 6'h01);
      op(4'h9, 32'hFFFFFFFF, 6'h20);
      op(4'h5, 32'hFFFFFFFF, 6'h00);
      op(4'h9, 32'hFFFFFFFF, 6'h21);
      op(4'h6, 32'h0, 6'h0);
      op(4'hA, 32'h0, 6'h0);
      op(4'hF, 32'h0, 6'h0);
      $display("corner test done");
      for (i = 0; i < 300; i++) begin
         rnd = lfsr(rnd);
         x = rnd;
         rnd = lfsr(rnd);
         op(rnd[3:0], x, rnd[9:4]);
      end
      $display("random test done");
      end_sim;
   end
endmodule
